// ==== pkg/cal_pkg.sv ====
// constants and types for the channel a active line length block
// assumes an apb slave with 32-bit data and word-aligned registers
`default_nettype none
package cal_pkg;
  localparam int unsigned LEN_W = 12;
  localparam int unsigned PIX_DATA_W = 24;
  localparam int unsigned APB_AW = 8;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHAN_CFG = 8'h10;
  localparam logic [7:0] IDX_LINK_CFG = 8'h18;
  localparam logic [7:0] IDX_LEN_LOW = 8'h20;
  localparam logic [7:0] IDX_LEN_HIGH = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  localparam logic [APB_AW-1:0] ADDR_CHAN_CFG = APB_AW'({IDX_CHAN_CFG, 2'h0});
  localparam logic [APB_AW-1:0] ADDR_LINK_CFG = APB_AW'({IDX_LINK_CFG, 2'h0});
  localparam logic [APB_AW-1:0] ADDR_LEN_LOW = APB_AW'({IDX_LEN_LOW, 2'h0});
  localparam logic [APB_AW-1:0] ADDR_LEN_HIGH = APB_AW'({IDX_LEN_HIGH, 2'h0});
  localparam logic [APB_AW-1:0] ADDR_STATUS = APB_AW'({IDX_STATUS, 2'h0});
  // field positions
  localparam int unsigned POS_SINGLE_OUT = 4;
  localparam int unsigned POS_CHAN_MODE = 5;
  localparam int unsigned POS_DUAL_IN = 1;
  localparam int unsigned POS_LR_SPLIT = 0;
  localparam int unsigned HIGH_NIBBLE_W = 4;
  localparam int unsigned POS_STAT_MODE = 12;
  // reset values
  localparam logic [7:0] RST_LEN_LOW = 8'h00;
  localparam logic [3:0] RST_LEN_HIGH = 4'h0;
  localparam logic RST_SINGLE_OUT = 1'b0;
  localparam logic [1:0] RST_CHAN_MODE = 2'h1;
  localparam logic RST_DUAL_IN = 1'b0;
  localparam logic RST_LR_SPLIT = 1'b0;
  // channel mode field encodings
  localparam logic [1:0] CHMODE_TWO_STREAM = 2'h2;
  localparam logic [1:0] CHMODE_ILLEGAL = 2'h3;

  typedef enum logic [2:0] {
    MODE_SINGLE,
    MODE_ODD_EVEN,
    MODE_LEFT_RIGHT,
    MODE_TWO_STREAM,
    MODE_BAD
  } cal_mode_t;
endpackage : cal_pkg
`default_nettype wire

// ==== logic/cal_pix_cnt.sv ====
// pixel counter for one active line, bounded by a programmed length
// assumes clear and increment come from logic on the same clock
`default_nettype none
module cal_pix_cnt #(
  parameter int unsigned W = 12
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic inc_in,
  input wire logic [W-1:0] limit_in,
  output logic [W-1:0] count_out,
  output logic take_out,
  output logic last_out
);
  generate
    if (W < 2) begin : g_bad_width
      $error("cal_pix_cnt needs a width of at least two");
    end
  endgenerate

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  wire logic [W-1:0] cur = clear_in ? '0 : count_q;
  wire logic active = cur < limit_in;
  wire logic [W-1:0] cur_plus = W'(cur + 1'b1);

  // a new line and a pixel in one cycle: that pixel is the first one
  assign take_out = inc_in && active;
  assign last_out = take_out && (cur_plus == limit_in);
  assign count_d = take_out ? cur_plus : cur;
  assign count_out = count_q;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : cal_pix_cnt
`default_nettype wire

// ==== logic/cal_line_len.sv ====
// channel a active line length registers and the line gate they steer
// assumes a single clock, apb from the same domain, video from same-clock logic
//
// Register access over APB was decided locally.
`default_nettype none
// Overview of operation
// - single input: length is active pixels per line
// - odd/even: length counts odd pixels on A
// - odd/even, single output: pixels to link A only
// - odd/even, dual output, mode 00/01: both links
// - left/right: length counts left pixels, A to A
// - two-stream: length counts stream A pixels
// - length is 12 bits, low byte bits 7:0
// - high nibble register bits 3:0 give 11:8
// - two-stream needs both outputs and mode 10
module cal_line_len (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [cal_pkg::APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic line_start_in,
  input wire logic pix_valid_in,
  input wire logic [cal_pkg::PIX_DATA_W-1:0] pix_data_in,
  output logic link_a_valid_out,
  output logic [cal_pkg::PIX_DATA_W-1:0] link_a_data_out,
  output logic link_b_valid_out,
  output logic [cal_pkg::PIX_DATA_W-1:0] link_b_data_out,
  output logic line_end_out
);
  localparam int unsigned DW = cal_pkg::PIX_DATA_W;

  logic [7:0] len_low_q;
  logic [3:0] len_high_q;
  logic single_out_q;
  logic [1:0] chan_mode_q;
  logic dual_in_q;
  logic lr_split_q;
  logic link_a_valid_q;
  logic link_b_valid_q;
  logic line_end_q;
  logic [DW-1:0] link_a_data_q;
  logic [DW-1:0] link_b_data_q;

  // apb decode
  wire logic access = psel_in && penable_in;
  wire logic wr_en = access && pwrite_in && pstrb_in[0];
  wire logic hit_chan = paddr_in == cal_pkg::ADDR_CHAN_CFG;
  wire logic hit_link = paddr_in == cal_pkg::ADDR_LINK_CFG;
  wire logic hit_low = paddr_in == cal_pkg::ADDR_LEN_LOW;
  wire logic hit_high = paddr_in == cal_pkg::ADDR_LEN_HIGH;
  wire logic hit_stat = paddr_in == cal_pkg::ADDR_STATUS;
  wire logic hit_any = hit_chan | hit_link | hit_low | hit_high | hit_stat;

  // line length assembled from both registers
  // each half acts from the cycle after its own write; a mixed value can show
  wire logic [cal_pkg::LEN_W-1:0] line_len = {len_high_q, len_low_q};

  // input/output mode decode
  cal_pkg::cal_mode_t mode;
  wire logic want_two = chan_mode_q == cal_pkg::CHMODE_TWO_STREAM;
  wire logic mode_illegal = chan_mode_q == cal_pkg::CHMODE_ILLEGAL;
  // two-stream with one output link enabled cannot be served, so it gates all
  assign mode = want_two ? (single_out_q ? cal_pkg::MODE_BAD
                                         : cal_pkg::MODE_TWO_STREAM)
              : mode_illegal ? cal_pkg::MODE_BAD
              : !dual_in_q ? cal_pkg::MODE_SINGLE
              : lr_split_q ? cal_pkg::MODE_LEFT_RIGHT
              : cal_pkg::MODE_ODD_EVEN;
  wire logic mode_ok = mode != cal_pkg::MODE_BAD;
  wire logic dual_out = (mode == cal_pkg::MODE_ODD_EVEN) && !single_out_q;

  // line gating
  logic [cal_pkg::LEN_W-1:0] pix_count;
  logic take;
  logic last;
  cal_pix_cnt #(
    .W(cal_pkg::LEN_W)
  ) u_cnt (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .clear_in(line_start_in),
    .inc_in(pix_valid_in && mode_ok),
    .limit_in(line_len),
    .count_out(pix_count),
    .take_out(take),
    .last_out(last)
  );

  // register reads; bits above a register's width read zero
  wire logic [31:0] rd_chan = 32'({chan_mode_q, 3'h0, dual_in_q, lr_split_q});
  wire logic [31:0] rd_link = 32'({single_out_q, 4'h0});
  wire logic [31:0] rd_stat = 32'({mode, pix_count});
  assign prdata_out = hit_chan ? rd_chan
                    : hit_link ? rd_link
                    : hit_low ? 32'(len_low_q)
                    : hit_high ? 32'(len_high_q)
                    : hit_stat ? rd_stat
                    : 32'h0000_0000;
  assign pready_out = 1'b1;
  assign pslverr_out = access && !hit_any;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      len_low_q <= cal_pkg::RST_LEN_LOW;
      len_high_q <= cal_pkg::RST_LEN_HIGH;
      single_out_q <= cal_pkg::RST_SINGLE_OUT;
      chan_mode_q <= cal_pkg::RST_CHAN_MODE;
      dual_in_q <= cal_pkg::RST_DUAL_IN;
      lr_split_q <= cal_pkg::RST_LR_SPLIT;
    end else if (wr_en) begin
      if (hit_low) begin
        len_low_q <= pwdata_in[7:0];
      end
      if (hit_high) begin
        len_high_q <= pwdata_in[cal_pkg::HIGH_NIBBLE_W-1:0];
      end
      if (hit_link) begin
        single_out_q <= pwdata_in[cal_pkg::POS_SINGLE_OUT];
      end
      if (hit_chan) begin
        chan_mode_q <= pwdata_in[cal_pkg::POS_CHAN_MODE+1:cal_pkg::POS_CHAN_MODE];
        dual_in_q <= pwdata_in[cal_pkg::POS_DUAL_IN];
        lr_split_q <= pwdata_in[cal_pkg::POS_LR_SPLIT];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_a_valid_q <= 1'b0;
      link_b_valid_q <= 1'b0;
      line_end_q <= 1'b0;
      link_a_data_q <= '0;
      link_b_data_q <= '0;
    end else begin
      link_a_valid_q <= take;
      link_b_valid_q <= take && dual_out;
      line_end_q <= last;
      if (take) begin
        link_a_data_q <= pix_data_in;
      end
      if (take && dual_out) begin
        link_b_data_q <= pix_data_in;
      end
    end
  end

  assign link_a_valid_out = link_a_valid_q;
  assign link_b_valid_out = link_b_valid_q;
  assign link_a_data_out = link_a_data_q;
  assign link_b_data_out = link_b_data_q;
  assign line_end_out = line_end_q;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  a_low_byte_write: assert property (
    wr_en && hit_low |=> line_len[7:0] == $past(pwdata_in[7:0]))
    else $error("low byte write not seen in line length");

  a_high_nibble_write: assert property (
    wr_en && hit_high |=> line_len[11:8] == $past(pwdata_in[3:0]))
    else $error("high nibble write not seen in line length");

  a_high_reads_zero: assert property (
    hit_high |-> prdata_out[31:4] == 28'h0000000)
    else $error("high nibble register upper bits not zero");

  a_pixel_passes: assert property (
    pix_valid_in && mode_ok && !line_start_in && pix_count < line_len |=> link_a_valid_out)
    else $error("active pixel not passed to link a");

  a_count_bound: assert property (
    link_a_valid_out |-> $past(line_start_in) || $past(pix_count) < $past(line_len))
    else $error("pixel passed beyond the line length");

  a_odd_single_link: assert property (
    mode == cal_pkg::MODE_ODD_EVEN && single_out_q && take |=> !link_b_valid_out)
    else $error("link b driven with a single output link");

  a_odd_both_links: assert property (
    mode == cal_pkg::MODE_ODD_EVEN && !single_out_q && take
      |=> link_b_valid_out && link_b_data_out == link_a_data_out)
    else $error("odd pixel not driven to both links");

  a_left_a_only: assert property (
    mode == cal_pkg::MODE_LEFT_RIGHT && take |=> link_a_valid_out && !link_b_valid_out)
    else $error("left pixel not confined to link a");

  a_stream_a_only: assert property (
    mode == cal_pkg::MODE_TWO_STREAM && take |=> link_a_valid_out && !link_b_valid_out)
    else $error("stream a pixel routing wrong");

  a_two_stream_gate: assert property (
    mode == cal_pkg::MODE_TWO_STREAM |-> !single_out_q && chan_mode_q == 2'h2)
    else $error("two-stream mode without its settings");

  a_bad_mode_drops: assert property (
    !mode_ok && pix_valid_in |=> !link_a_valid_out && !link_b_valid_out)
    else $error("pixel passed in an unusable mode");

  a_data_follows: assert property (
    take |=> link_a_data_out == $past(pix_data_in))
    else $error("link a data differs from the taken pixel");

  a_unmapped_error: assert property (
    access && !hit_any |-> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not flagged");

  c_line_complete: cover property (line_end_out && line_len > 12'h001);
  c_dual_links: cover property (link_b_valid_out ##1 link_b_valid_out);
  c_two_stream: cover property (mode == cal_pkg::MODE_TWO_STREAM && take);
  c_left_right: cover property (mode == cal_pkg::MODE_LEFT_RIGHT && last);
  c_odd_single: cover property (mode == cal_pkg::MODE_ODD_EVEN && single_out_q && take);
endmodule : cal_line_len
`default_nettype wire

// ==== tb/cal_video_src.sv ====
// behavioural video source feeding channel a of the line length block
// assumes one clock shared with the block; starts a line on a go pulse
`default_nettype none
module cal_video_src (
  input wire logic clock_in,
  input wire logic go_in,
  input wire logic [11:0] n_in,
  output logic line_start_out,
  output logic pix_valid_out,
  output logic [23:0] pix_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] left_q = 12'h000;
  logic [11:0] n_q = 12'h000;
  logic [11:0] cyc_q = 12'h000;
  logic first_q = 1'b0;
  always_ff @(posedge clock_in) begin
    cyc_q <= cyc_q + 12'h001;
    first_q <= go_in;
    if (go_in) begin
      left_q <= n_in;
      n_q <= n_in;
    end else if (left_q != 12'h000) begin
      left_q <= left_q - 12'h001;
    end
  end
  // one pixel per strobe, back to back; idle data keeps moving
  assign pix_valid_out = left_q != 12'h000;
  assign line_start_out = first_q;
  assign pix_data_out = pix_valid_out ? {12'ha00, n_q - left_q} : {12'h5a5, cyc_q};
endmodule : cal_video_src
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the channel a line length block
// assumes zero-wait apb and the video source model beside the block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err, ls, pv, av, bv, le;
  logic [23:0] pd, ad, bd;
  logic [11:0] src_n = 12'h000;
  int num_errors = 0, tests_run = 0, ca, cb, ce, cyc = 0;
  logic [7:0] cfgs [8] = '{8'h20, 8'h22, 8'h22, 8'h02, 8'h23, 8'h40, 8'h40, 8'h60};
  logic [7:0] links [8] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
  logic [7:0] a_on = 8'h3f;
  logic [7:0] b_on = 8'h0c;
  cal_line_len cal_line_len_inst (.clock_in(clock), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .line_start_in(ls), .pix_valid_in(pv), .pix_data_in(pd), .link_a_valid_out(av),
    .link_a_data_out(ad), .link_b_valid_out(bv), .link_b_data_out(bd), .line_end_out(le));
  cal_video_src cal_video_src_inst (.clock_in(clock), .go_in(go), .n_in(src_n),
    .line_start_out(ls), .pix_valid_out(pv), .pix_data_out(pd));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // counting on the falling edge keeps clear of the launching edge
  always @(negedge clock) begin
    ca += int'(av === 1'b1);
    cb += int'(bv === 1'b1);
    ce += int'(le === 1'b1);
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic run_line(input logic [11:0] n);
    ca = 0;
    cb = 0;
    ce = 0;
    go <= 1'b1;
    src_n <= n;
    @(posedge clock);
    go <= 1'b0;
    repeat (int'(n) + 4) @(posedge clock);
  endtask : run_line
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, cal_pkg::ADDR_LEN_LOW, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, cal_pkg::ADDR_LEN_HIGH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, cal_pkg::ADDR_LEN_LOW, 32'h03);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, cal_pkg::ADDR_CHAN_CFG, {24'h0, cfgs[i]});
      apb(1'b1, cal_pkg::ADDR_LINK_CFG, {24'h0, links[i]});
      run_line(12'h005);
      chk(ca, a_on[i] ? 3 : 0);
      chk(cb, b_on[i] ? 3 : 0);
      chk(ce, a_on[i] ? 1 : 0);
      if (a_on[i]) chk(ad, 32'ha00002);
      if (b_on[i]) chk(bd, 32'ha00002);
    end
    apb(1'b1, cal_pkg::ADDR_CHAN_CFG, 32'h20);
    apb(1'b1, cal_pkg::ADDR_LINK_CFG, 32'h00);
    apb(1'b1, cal_pkg::ADDR_LEN_HIGH, 32'hf1);
    apb(1'b1, cal_pkg::ADDR_LEN_LOW, 32'h02);
    apb(1'b0, cal_pkg::ADDR_LEN_HIGH, 32'h0);
    chk(rd, 32'h01);
    apb(1'b0, cal_pkg::ADDR_LEN_LOW, 32'h0);
    chk(rd, 32'h02);
    run_line(12'h106);
    chk(ca, 258);
    chk(ad, 32'ha00101);
    apb(1'b0, cal_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h102);
    // mid-run reset: registers must fall back to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, cal_pkg::ADDR_LEN_LOW, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, cal_pkg::ADDR_CHAN_CFG, 32'h0);
    chk(rd, 32'h20);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
